// [include/pbc_pkg.sv]
// Constants for the transceiver basic control low-bits register bank
package pbc_pkg;
    // ------------------------------------------------------------
    // Register word indices and byte offsets on the bus
    // ------------------------------------------------------------
    localparam logic [1:0] REG_CONTROL = 2'h0;
    localparam logic [1:0] REG_COPPER = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam logic [31:0] ADDR_CONTROL = 32'h0000_0000;
    localparam logic [31:0] ADDR_COPPER = 32'h0000_0004;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
    localparam int ADDR_LIMIT = 12;

    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int CTL_SOFT_RESET = 15;
    localparam int CTL_SPEED_LO = 13;
    localparam int CTL_POWER_DOWN = 11;
    localparam int CTL_ISOLATE = 10;
    localparam int CTL_RESTART = 9;
    localparam int CTL_DUPLEX = 8;
    localparam int CTL_COLL_TEST = 7;
    localparam int CTL_SPEED_HI = 6;

    // Copper specific control fields
    localparam int CSC_POWER_DOWN = 0;
    localparam int CSC_KEEP_ALIVE = 1;

    // Status register fields
    localparam int STS_DUPLEX = 0;
    localparam int STS_SPEED_LO = 1;
    localparam int STS_SPEED_HI = 2;
    localparam int STS_POWERED_DOWN = 3;
    localparam int STS_GMII_OFF = 4;
    localparam int STS_IN_RESET = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_DUPLEX = 1'h1;
    localparam logic RST_SPEED_HI = 1'h1;
    localparam logic RST_SPEED_LO = 1'h0;
    localparam logic RST_RESTART = 1'h0;
    localparam logic RST_PD2 = 1'h0;
    localparam logic RST_KEEP_ALIVE = 1'h0;

    // Speed codes {upper, lower}
    localparam logic [1:0] SPEED_1000 = 2'h2;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_RSVD = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SRST_TIME_NS = 40;
    localparam int SRST_CYCLES_INT =
        (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SRST_CYCLES = 3'(SRST_CYCLES_INT);

    // Soft reset sequencer states
    typedef enum logic {
        PBC_RUN,
        PBC_SRST
    } pbc_state_type;
endpackage

// [design/pbc_ctrl.sv]
// Transceiver basic control register, bits 15..0, with AHB-Lite access
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// - Stay powered down until both power-down bits are zero.
// - Leaving power-down forces a soft reset and negotiation restart.
// - Keep-alive bit keeps GMII powered in power-down; otherwise GMII shuts down with the PHY.
// - After hardware reset, power-down bit loads from core request.
// - Core request falling edge clears power-down, rising edge sets.
// - Isolate and collision-test bits read zero, have no effect.
// - Negotiation restarts after every hardware and software reset.
// - Writing restart bit restarts negotiation, then self-clears.
// - Core restart request rising edge sets the restart bit.
// - Duplex bit resets full, applied only on reset, restart or wake.
// - Speed bits form code: 10 gigabit, 01 hundred, 11 reserved.
// - Speed upper resets one, stays pending until an update event.
// - Soft reset bit resets state machines, self-clears on completion.
module pbc_ctrl
    import pbc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic core_power_down_request,
    input wire logic core_negotiation_restart_request,
    output logic phy_power_down,
    output logic gmii_power_down,
    output logic phy_state_reset,
    output logic negotiation_restart,
    output logic duplex_full,
    output logic [1:0] speed_code,
    output logic speed_reserved
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Word index of a byte address, with a valid flag
    function automatic logic [2:0] decode(input logic [31:0] a);
        logic [2:0] r;
        r = 3'h0;
        if (a < 32'(ADDR_LIMIT) && a[1:0] == 2'h0) begin
            r = {1'b1, a[3:2]};
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Bus slave state
    // ------------------------------------------------------------
    logic dp_write, next_dp_write;
    logic dp_read, next_dp_read;
    logic rd_done, next_rd_done;
    logic [2:0] dp_idx, next_dp_idx;
    logic [31:0] next_hrdata;
    logic addr_take;
    logic wr_ctl, wr_csc;

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    pbc_state_type state, next_state;
    logic [2:0] srst_cnt, next_srst_cnt;
    logic init_done, next_init_done;
    logic ctl_pd, next_ctl_pd;
    logic ctl_restart, next_ctl_restart;
    logic ctl_duplex, next_ctl_duplex;
    logic ctl_speed_hi, next_ctl_speed_hi;
    logic ctl_speed_lo, next_ctl_speed_lo;
    logic csc_pd2, next_csc_pd2;
    logic csc_keep, next_csc_keep;
    logic app_duplex, next_app_duplex;
    logic [1:0] app_speed, next_app_speed;
    logic pd_out, next_pd_out;
    logic gmii_out, next_gmii_out;
    logic req_pd_q, req_an_q;
    logic powered, wake, srst_start, srst_end, update;
    logic pd_rise, pd_fall, an_rise;

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Reads take one wait state so a preceding write is visible
    assign addr_take = hsel & hready & htrans[1];
    assign hreadyout = ~(dp_read & ~rd_done);
    assign hresp = 1'b0;
    assign wr_ctl = dp_write && dp_idx == {1'b1, REG_CONTROL};
    assign wr_csc = dp_write && dp_idx == {1'b1, REG_COPPER};

    // Next bus phase and read data
    always_comb begin
        next_dp_write = dp_write;
        next_dp_read = dp_read;
        next_dp_idx = dp_idx;
        next_rd_done = 1'b0;
        next_hrdata = hrdata;
        if (hreadyout) begin
            next_dp_write = addr_take & hwrite;
            next_dp_read = addr_take & ~hwrite;
            next_dp_idx = addr_take ? decode(haddr) : 3'h0;
        end else begin
            next_rd_done = 1'b1;
            next_hrdata = 32'h0000_0000;
            case (dp_idx)
                {1'b1, REG_CONTROL}: begin
                    next_hrdata[CTL_SOFT_RESET] = state == PBC_SRST;
                    next_hrdata[CTL_SPEED_LO] = ctl_speed_lo;
                    next_hrdata[CTL_POWER_DOWN] = ctl_pd;
                    next_hrdata[CTL_RESTART] = ctl_restart;
                    next_hrdata[CTL_DUPLEX] = ctl_duplex;
                    next_hrdata[CTL_SPEED_HI] = ctl_speed_hi;
                end
                {1'b1, REG_COPPER}: begin
                    next_hrdata[CSC_POWER_DOWN] = csc_pd2;
                    next_hrdata[CSC_KEEP_ALIVE] = csc_keep;
                end
                {1'b1, REG_STATUS}: begin
                    next_hrdata[STS_DUPLEX] = app_duplex;
                    next_hrdata[STS_SPEED_LO] = app_speed[0];
                    next_hrdata[STS_SPEED_HI] = app_speed[1];
                    next_hrdata[STS_POWERED_DOWN] = pd_out;
                    next_hrdata[STS_GMII_OFF] = gmii_out;
                    next_hrdata[STS_IN_RESET] = state == PBC_SRST;
                end
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end
    // Bus registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            rd_done <= 1'b0;
            dp_idx <= 3'h0;
            hrdata <= 32'h0000_0000;
        end else begin
            dp_write <= next_dp_write;
            dp_read <= next_dp_read;
            rd_done <= next_rd_done;
            dp_idx <= next_dp_idx;
            hrdata <= next_hrdata;
        end
    end

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    // powered down while either bit is set
    assign powered = ctl_pd | csc_pd2;
    // wake: output still down, both bits already clear
    assign wake = init_done & pd_out & ~powered;
    assign pd_rise = init_done & core_power_down_request & ~req_pd_q;
    assign pd_fall = init_done & ~core_power_down_request & req_pd_q;
    assign an_rise = init_done & core_negotiation_restart_request & ~req_an_q;
    // soft reset starts at once on a write of one
    assign srst_start = wake | (wr_ctl & hwdata[CTL_SOFT_RESET]);
    assign srst_end = state == PBC_SRST && srst_cnt == 3'h1;
    // pending duplex and speed copied on these events
    assign update = srst_start | ctl_restart;

    // ------------------------------------------------------------
    // Control next values
    // ------------------------------------------------------------
    always_comb begin
        next_init_done = 1'b1;
        next_state = state;
        next_srst_cnt = srst_cnt;
        next_ctl_pd = ctl_pd;
        next_ctl_restart = 1'b0;
        next_ctl_duplex = ctl_duplex;
        next_ctl_speed_hi = ctl_speed_hi;
        next_ctl_speed_lo = ctl_speed_lo;
        next_csc_pd2 = csc_pd2;
        next_csc_keep = csc_keep;
        next_app_duplex = app_duplex;
        next_app_speed = app_speed;
        // Software writes first, hardware events override below
        if (wr_ctl) begin
            next_ctl_pd = hwdata[CTL_POWER_DOWN];
            next_ctl_duplex = hwdata[CTL_DUPLEX];
            next_ctl_speed_hi = hwdata[CTL_SPEED_HI];
            next_ctl_speed_lo = hwdata[CTL_SPEED_LO];
            next_ctl_restart = hwdata[CTL_RESTART];
        end
        if (wr_csc) begin
            next_csc_pd2 = hwdata[CSC_POWER_DOWN];
            next_csc_keep = hwdata[CSC_KEEP_ALIVE];
        end
        // first edge after release samples the request
        if (!init_done) begin
            next_ctl_pd = core_power_down_request;
        end
        // request edges beat a software write
        if (pd_rise) begin
            next_ctl_pd = 1'b1;
        end
        if (pd_fall) begin
            next_ctl_pd = 1'b0;
        end
        // restart after hardware and software reset
        // core request edge sets the restart bit
        if (!init_done || srst_end || an_rise) begin
            next_ctl_restart = 1'b1;
        end
        // speed applied only on an update event
        if (update) begin
            next_app_duplex = next_ctl_duplex;
            next_app_speed = {next_ctl_speed_hi, next_ctl_speed_lo};
        end
        // power-down bit is not touched here
        case (state)
            PBC_RUN: begin
                if (srst_start) begin
                    next_state = PBC_SRST;
                    next_srst_cnt = SRST_CYCLES;
                end
            end
            PBC_SRST: begin
                next_srst_cnt = srst_cnt - 3'h1;
                if (srst_end) begin
                    next_state = PBC_RUN;
                end
            end
            default: next_state = PBC_RUN;
        endcase
        // output lags the bits by one cycle so wake sees the fall
        next_pd_out = powered;
        // GMII follows keep-alive while powered down
        next_gmii_out = powered & ~csc_keep;
    end
    // Control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_done <= 1'b0;
            state <= PBC_RUN;
            srst_cnt <= 3'h0;
            ctl_pd <= 1'b0;
            ctl_restart <= RST_RESTART;
            ctl_duplex <= RST_DUPLEX;
            ctl_speed_hi <= RST_SPEED_HI;
            ctl_speed_lo <= RST_SPEED_LO;
            csc_pd2 <= RST_PD2;
            csc_keep <= RST_KEEP_ALIVE;
            app_duplex <= RST_DUPLEX;
            app_speed <= {RST_SPEED_HI, RST_SPEED_LO};
            pd_out <= 1'b0;
            gmii_out <= 1'b0;
            req_pd_q <= 1'b0;
            req_an_q <= 1'b0;
        end else begin
            init_done <= next_init_done;
            state <= next_state;
            srst_cnt <= next_srst_cnt;
            ctl_pd <= next_ctl_pd;
            ctl_restart <= next_ctl_restart;
            ctl_duplex <= next_ctl_duplex;
            ctl_speed_hi <= next_ctl_speed_hi;
            ctl_speed_lo <= next_ctl_speed_lo;
            csc_pd2 <= next_csc_pd2;
            csc_keep <= next_csc_keep;
            app_duplex <= next_app_duplex;
            app_speed <= next_app_speed;
            pd_out <= next_pd_out;
            gmii_out <= next_gmii_out;
            req_pd_q <= core_power_down_request;
            req_an_q <= core_negotiation_restart_request;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign phy_power_down = pd_out;
    assign gmii_power_down = gmii_out;
    assign phy_state_reset = state == PBC_SRST;
    assign negotiation_restart = ctl_restart;
    assign duplex_full = app_duplex;
    assign speed_code = app_speed;
    assign speed_reserved = app_speed == SPEED_RSVD;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_srst_run;
        phy_state_reset [*4] ##1 !phy_state_reset;
    endsequence
    sequence s_srst_done;
        phy_state_reset ##1 !phy_state_reset;
    endsequence

    a_pd_both_bits: assert property (
        (ctl_pd || csc_pd2) |=> phy_power_down)
        else $error("power-down left while a bit is set");
    a_wake_reset: assert property (
        (init_done && $fell(phy_power_down)) |-> ##[0:1] phy_state_reset)
        else $error("wake without soft reset");
    a_gmii_keep: assert property (
        $past(init_done) |->
        gmii_power_down == (phy_power_down && !$past(csc_keep)))
        else $error("GMII power state wrong");
    a_pd_loaded: assert property (
        $rose(init_done) |-> ctl_pd == $past(core_power_down_request))
        else $error("power-down not loaded from request");
    a_pd_edges: assert property (
        (init_done && $rose(core_power_down_request)) |=> ctl_pd)
        else $error("rising request did not set power-down");
    a_ro_bits: assert property (
        (rd_done && dp_idx == {1'b1, REG_CONTROL}) |->
        (hrdata[CTL_ISOLATE] == 1'b0 && hrdata[CTL_COLL_TEST] == 1'b0))
        else $error("isolate or collision bit reads one");
    a_restart_srst: assert property (
        s_srst_done |-> negotiation_restart)
        else $error("no restart after soft reset");
    a_restart_clear: assert property (
        negotiation_restart && !wr_ctl && !an_rise && !srst_end
        |=> !negotiation_restart)
        else $error("restart bit did not clear");
    a_core_restart: assert property (
        (init_done && $rose(core_negotiation_restart_request))
        |=> negotiation_restart)
        else $error("core restart edge lost");
    a_duplex_hold: assert property (
        !update |=> $stable(duplex_full))
        else $error("duplex changed without update");
    a_speed_hold: assert property (
        !update |=> $stable(speed_code))
        else $error("speed changed without update");
    a_srst_len: assert property (
        $rose(phy_state_reset) |-> s_srst_run)
        else $error("soft reset length wrong");
    a_rsvd_zero: assert property (
        (rd_done && dp_idx == {1'b1, REG_CONTROL}) |->
        hrdata[5:0] == 6'h00)
        else $error("reserved bits read nonzero");
endmodule

// [tb/tb.sv]
// Self-checking testbench for the transceiver basic control register bank
`timescale 1ns/1ns
module tb;
    import pbc_pkg::*;
    // ------------------------------------------------------------
    // Signals and design instance
    // ------------------------------------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic core_power_down_request = 1'b0;
    logic core_negotiation_restart_request = 1'b0;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic phy_power_down;
    wire logic gmii_power_down;
    wire logic phy_state_reset;
    wire logic negotiation_restart;
    wire logic duplex_full;
    wire logic [1:0] speed_code;
    wire logic speed_reserved;
    int error_cnt = 0;
    int n_tests = 0;
    int hi;
    int pl;

    // Single slave, so its ready is the bus ready
    pbc_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata),
        .core_power_down_request(core_power_down_request),
        .core_negotiation_restart_request(core_negotiation_restart_request),
        .phy_power_down(phy_power_down), .gmii_power_down(gmii_power_down),
        .phy_state_reset(phy_state_reset),
        .negotiation_restart(negotiation_restart),
        .duplex_full(duplex_full), .speed_code(speed_code),
        .speed_reserved(speed_reserved));

    // 100 MHz clock
    always #5 hclk = ~hclk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // Ready sampled at the falling edge is what the next rising edge sees
    task automatic wait_rdy(output logic [31:0] d);
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(negedge hclk);
        end
        // A ready that never came counts as a mismatch
        if (hreadyout !== 1'b1) error_cnt++;
        d = hrdata;
        @(posedge hclk);
    endtask

    // Entered just after a rising edge; returns at the data phase's end
    task automatic bus_xfer(input logic wr, input logic [31:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        logic [31:0] tmp;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy(tmp);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(rd);
    endtask

    task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] tmp;
        bus_xfer(1'b1, a, d, tmp);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus_xfer(1'b0, a, 32'h0, r);
        check(r, exp);
    endtask

    // Counts soft-reset cycles and restart pulses over n cycles
    task automatic watch(input int n, output int h, output int p);
        h = 0;
        p = 0;
        repeat (n) begin
            @(negedge hclk);
            if (phy_state_reset === 1'b1) h++;
            if (negotiation_restart === 1'b1) p++;
        end
        @(posedge hclk);
    endtask

    task automatic hw_reset(input logic pd);
        hresetn <= 1'b0;
        core_power_down_request <= pd;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        @(negedge hclk);
        check({31'h0, negotiation_restart}, 32'h1);
        @(negedge hclk);
        check({31'h0, negotiation_restart}, 32'h0);
        @(posedge hclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset values, read-only and reserved bits, unmapped address
    task automatic t_regs();
        rd_chk(ADDR_CONTROL, 32'h0000_0140);
        check({29'h0, duplex_full, speed_code}, 32'h6);
        bus_write(ADDR_CONTROL, 32'h0000_05FF);
        rd_chk(ADDR_CONTROL, 32'h0000_0140);
        bus_write(32'h0000_000C, 32'hFFFF_FFFF);
        rd_chk(32'h0000_000C, 32'h0);
        check({31'h0, hresp}, 32'h0);
        rd_chk(ADDR_COPPER, 32'h0);
    endtask

    // Duplex waits for a restart before it applies
    task automatic t_pending();
        bus_write(ADDR_CONTROL, 32'h0000_0040);
        rd_chk(ADDR_CONTROL, 32'h0000_0040);
        check({31'h0, duplex_full}, 32'h1);
        rd_chk(ADDR_STATUS, 32'h0000_0005);
        bus_write(ADDR_CONTROL, 32'h0000_0240);
        watch(4, hi, pl);
        check(32'(pl), 32'h1);
        check({31'h0, duplex_full}, 32'h0);
        rd_chk(ADDR_CONTROL, 32'h0000_0040);
    endtask

    // Speed codes 01, 11 and 10, each applied by a soft reset
    task automatic t_speed();
        logic [1:0] codes [3];
        logic [31:0] val;
        codes = '{2'h1, 2'h3, 2'h2};
        for (int i = 0; i < 3; i++) begin
            val = 32'h0000_8100 | (32'(codes[i][0]) << 13) |
                (32'(codes[i][1]) << 6);
            bus_write(ADDR_CONTROL, val);
            watch(12, hi, pl);
            check(32'(hi), 32'h4);
            check(32'(pl), 32'h1);
            check({30'h0, speed_code}, {30'h0, codes[i]});
            check({31'h0, speed_reserved}, {31'h0, &codes[i]});
            rd_chk(ADDR_CONTROL, val & 32'h0000_7FFF);
        end
    endtask

    // Power-down through both bits, keep-alive, wake sequence
    task automatic t_pdown();
        bus_write(ADDR_COPPER, 32'h0000_0002);
        bus_write(ADDR_CONTROL, 32'h0000_0940);
        repeat (2) @(posedge hclk);
        check({31'h0, phy_power_down}, 32'h1);
        check({31'h0, gmii_power_down}, 32'h0);
        bus_write(ADDR_CONTROL, 32'h0000_8940);
        watch(12, hi, pl);
        rd_chk(ADDR_CONTROL, 32'h0000_0940);
        check({31'h0, phy_power_down}, 32'h1);
        bus_write(ADDR_COPPER, 32'h0000_0003);
        bus_write(ADDR_COPPER, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        check({31'h0, gmii_power_down}, 32'h1);
        bus_write(ADDR_CONTROL, 32'h0000_0040);
        repeat (2) @(posedge hclk);
        check({31'h0, phy_power_down}, 32'h1);
        check({31'h0, duplex_full}, 32'h1);
        rd_chk(ADDR_STATUS, 32'h0000_001D);
        bus_write(ADDR_COPPER, 32'h0);
        watch(12, hi, pl);
        check(32'(hi), 32'h4);
        check(32'(pl), 32'h1);
        check({30'h0, phy_power_down, gmii_power_down}, 32'h0);
        check({31'h0, duplex_full}, 32'h0);
    endtask

    // Core request inputs, after a hardware reset taken while held down
    task automatic t_core();
        hw_reset(1'b1);
        rd_chk(ADDR_CONTROL, 32'h0000_0940);
        check({31'h0, phy_power_down}, 32'h1);
        check({31'h0, duplex_full}, 32'h1);
        core_power_down_request <= 1'b0;
        watch(14, hi, pl);
        check(32'(hi), 32'h4);
        rd_chk(ADDR_CONTROL, 32'h0000_0140);
        core_power_down_request <= 1'b1;
        repeat (3) @(posedge hclk);
        rd_chk(ADDR_CONTROL, 32'h0000_0940);
        check({31'h0, phy_power_down}, 32'h1);
        core_power_down_request <= 1'b0;
        watch(14, hi, pl);
        core_negotiation_restart_request <= 1'b1;
        watch(6, hi, pl);
        check(32'(pl), 32'h1);
        watch(6, hi, pl);
        check(32'(pl), 32'h0);
        core_negotiation_restart_request <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        @(posedge hclk);
        hw_reset(1'b0);
        t_regs();
        t_pending();
        t_speed();
        t_pdown();
        t_core();
        report_and_stop();
    end

    // Whole run is well under a thousand cycles
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
endmodule
